// ---- hdl/dts_params.svh ----
// timing constants for the data lane burst sequencer
`ifndef DTS_PARAMS_SVH
`define DTS_PARAMS_SVH
`define DTS_CLK_PS 25000
`define DTS_PREP_MIN_NS 40
`define DTS_PREP_MAX_NS 85
`define DTS_PREP_ZERO_NS 145
`define DTS_TRAIL_NS 60
`define DTS_EOT_MAX_NS 105
`define DTS_EXIT_NS 100
`define DTS_LPX_NS 50
`define DTS_WAKE_MS 1
`define DTS_INIT_US 100
`define DTS_PREP_UI 4
`define DTS_ZERO_UI 10
`define DTS_TRAIL_UI 4
`define DTS_CLKPRE_EDGES 2
`define DTS_EXIT_CYC ((`DTS_EXIT_NS * 1000 + `DTS_CLK_PS - 1) / `DTS_CLK_PS)
`define DTS_LPX_CYC ((`DTS_LPX_NS * 1000 + `DTS_CLK_PS - 1) / `DTS_CLK_PS)
`define DTS_INIT_CYC ((`DTS_INIT_US * 1000000 + `DTS_CLK_PS - 1) / `DTS_CLK_PS)
`define DTS_WAKE_CYC ((`DTS_WAKE_MS * 1000000000 + `DTS_CLK_PS - 1) / `DTS_CLK_PS)
`endif

// ---- hdl/dts_pkg.sv ----
// types for the data lane burst sequencer
package dts_pkg;
  typedef enum logic [12:0] {
    ST_INIT = 13'h0001,
    ST_STOP = 13'h0002,
    ST_CLKPRE = 13'h0004,
    ST_HSRQ = 13'h0008,
    ST_PREP = 13'h0010,
    ST_ZERO = 13'h0020,
    ST_DATA = 13'h0040,
    ST_TRAIL = 13'h0080,
    ST_EXIT = 13'h0100,
    ST_ESCRQ = 13'h0200,
    ST_ESCGO = 13'h0400,
    ST_ULPS = 13'h0800,
    ST_WAKE = 13'h1000
  } dts_state_t;
endpackage

// ---- hdl/dts_lane_seq.sv ----
// data lane burst timing sequencer for the camera serial output
//
// Summary of operation
// - prepare 40ns+4UI..85ns+6UI, prepare+zero >=145ns+10UI
// - trail >=60ns+4UI, trail to LP-11 bounded
// - LP-11 held >=100ns after every burst
// - every low-power line state lasts >=50ns
// - ULPS exit holds mark >=1ms
// - clock lane runs >=8UI before data entry
`timescale 1ns/100ps
`default_nettype none
`include "dts_params.svh"

module dts_lane_seq #(
  parameter int WAKE_CYC = `DTS_WAKE_CYC,
  parameter int INIT_CYC = `DTS_INIT_CYC,
  parameter int UI_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [UI_W-1:0] ui_ps,
  input wire logic tx_req,
  input wire logic tx_last,
  input wire logic ulps_req,
  input wire logic ulps_exit,
  input wire logic clk_lane_run,
  input wire logic byte_clk,
  output logic lp_p,
  output logic lp_n,
  output logic hs_drive,
  output logic hs_zero,
  output logic payload_ok,
  output logic lane_ready,
  output logic ulps_active
);
  import dts_pkg::*;

  dts_state_t state_r;
  dts_state_t state_nxt;
  logic [31:0] ps_r;
  logic [31:0] ps_nxt;
  logic [19:0] cyc_r;
  logic [19:0] cyc_nxt;
  logic run_s1_r;
  logic run_s2_r;
  logic bclk_s1_r;
  logic bclk_s2_r;
  logic bclk_d_r;
  logic [1:0] edges_r;
  logic [1:0] edges_nxt;
  logic [31:0] prep_min_r;
  logic [31:0] prep_min_nxt;
  logic [31:0] zero_tot_r;
  logic [31:0] zero_tot_nxt;
  logic [31:0] trail_r;
  logic [31:0] trail_nxt;

  // clk_lane_run and byte_clk pass two flops before anything reads them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_s1_r <= 1'b0;
      run_s2_r <= 1'b0;
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      bclk_d_r <= 1'b0;
    end else begin
      run_s1_r <= clk_lane_run;
      run_s2_r <= run_s1_r;
      bclk_s1_r <= byte_clk;
      bclk_s2_r <= bclk_s1_r;
      bclk_d_r <= bclk_s2_r;
    end
  end

  // ui-scaled targets in picoseconds; elapsed time is compared, so minima round up
  wire [31:0] ui_w = {{(32-UI_W){1'b0}}, ui_ps};
  wire [31:0] prep_min_ps = 32'(`DTS_PREP_MIN_NS * 1000) + 32'(`DTS_PREP_UI) * ui_w;
  wire [31:0] zero_tot_ps = 32'(`DTS_PREP_ZERO_NS * 1000) + 32'(`DTS_ZERO_UI) * ui_w;
  wire [31:0] trail_ps = 32'(`DTS_TRAIL_NS * 1000) + 32'(`DTS_TRAIL_UI) * ui_w;
  wire bclk_rise = bclk_s2_r & ~bclk_d_r;

  // targets are captured while the line still idles, so a unit interval that
  // moves during a burst cannot stretch or cut a phase already running;
  // this also keeps the multipliers out of the comparator path
  wire tgt_load = state_r inside {ST_STOP, ST_CLKPRE, ST_HSRQ};
  assign prep_min_nxt = tgt_load ? prep_min_ps : prep_min_r;
  assign zero_tot_nxt = tgt_load ? zero_tot_ps : zero_tot_r;
  assign trail_nxt = tgt_load ? trail_ps : trail_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prep_min_r <= 32'h00000000;
      zero_tot_r <= 32'h00000000;
      trail_r <= 32'h00000000;
    end else begin
      prep_min_r <= prep_min_nxt;
      zero_tot_r <= zero_tot_nxt;
      trail_r <= trail_nxt;
    end
  end

  // one byte clock period is 8 UI; two rising edges seen guarantee a full period
  wire clkpre_done = run_s2_r && (edges_r == 2'(`DTS_CLKPRE_EDGES));
  // leaving prepare at the first edge past the minimum stays under the maximum
  wire prep_done = ps_r >= prep_min_r;
  wire zero_done = ps_r >= zero_tot_r;
  // trail ends at first edge past its minimum, well inside the end-of-burst bound
  wire trail_done = ps_r >= trail_r;
  wire exit_done = cyc_r >= 20'(`DTS_EXIT_CYC);
  wire lpx_done = cyc_r >= 20'(`DTS_LPX_CYC);
  wire wake_done = cyc_r >= 20'(WAKE_CYC);
  wire init_done = cyc_r >= 20'(INIT_CYC);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_INIT: begin
        if (init_done) state_nxt = ST_STOP;
      end
      ST_STOP: begin
        if (ulps_req) begin
          state_nxt = ST_ESCRQ;
        end else if (tx_req) begin
          state_nxt = ST_CLKPRE;
        end
      end
      ST_CLKPRE: begin
        if (clkpre_done) state_nxt = ST_HSRQ;
      end
      ST_HSRQ: begin
        if (lpx_done) state_nxt = ST_PREP;
      end
      ST_PREP: begin
        if (prep_done) state_nxt = ST_ZERO;
      end
      ST_ZERO: begin
        if (zero_done) state_nxt = ST_DATA;
      end
      ST_DATA: begin
        if (tx_last) state_nxt = ST_TRAIL;
      end
      ST_TRAIL: begin
        if (trail_done) state_nxt = ST_EXIT;
      end
      ST_EXIT: begin
        if (exit_done) state_nxt = ST_STOP;
      end
      ST_ESCRQ: begin
        if (lpx_done) state_nxt = ST_ESCGO;
      end
      ST_ESCGO: begin
        if (lpx_done) state_nxt = ST_ULPS;
      end
      ST_ULPS: begin
        if (ulps_exit) state_nxt = ST_WAKE;
      end
      ST_WAKE: begin
        if (wake_done) state_nxt = ST_EXIT;
      end
      default: state_nxt = ST_INIT;
    endcase
  end

  // prepare and zero share one elapsed-time count so their sum is checked directly
  wire keep_time = (state_nxt == state_r) || (state_r == ST_PREP && state_nxt == ST_ZERO);
  assign ps_nxt = keep_time ? ps_r + 32'(`DTS_CLK_PS) : 32'(`DTS_CLK_PS);
  // counts may wrap in long idle states; harmless, every timed state restarts them except zero, which continues the prepare count
  assign cyc_nxt = (state_nxt == state_r) ? cyc_r + 20'h00001 : 20'h00001;
  wire edge_sat = edges_r == 2'(`DTS_CLKPRE_EDGES);
  wire in_pre = state_r == ST_CLKPRE && run_s2_r;
  assign edges_nxt = !in_pre ? 2'h0 : (bclk_rise && !edge_sat) ? edges_r + 2'h1 : edges_r;

  // line levels decoded from the next state so outputs come straight from flops
  wire lp11_nxt = state_nxt inside {ST_INIT, ST_STOP, ST_CLKPRE, ST_EXIT};
  wire p_nxt = lp11_nxt || state_nxt inside {ST_ESCRQ, ST_WAKE};
  wire n_nxt = lp11_nxt || state_nxt == ST_HSRQ;
  wire hs_nxt = state_nxt inside {ST_ZERO, ST_DATA, ST_TRAIL};
  wire zero_nxt = state_nxt == ST_ZERO;
  wire pay_nxt = state_nxt == ST_DATA;
  wire rdy_nxt = state_nxt == ST_STOP;
  wire ulps_nxt = state_nxt inside {ST_ULPS, ST_WAKE};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_INIT;
      ps_r <= 32'h00000000;
      cyc_r <= 20'h00000;
      edges_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      ps_r <= ps_nxt;
      cyc_r <= cyc_nxt;
      edges_r <= edges_nxt;
    end
  end

  // reset parks the lane at LP-11, the stop state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lp_p <= 1'b1;
      lp_n <= 1'b1;
      hs_drive <= 1'b0;
      hs_zero <= 1'b0;
      payload_ok <= 1'b0;
      lane_ready <= 1'b0;
      ulps_active <= 1'b0;
    end else begin
      lp_p <= p_nxt;
      lp_n <= n_nxt;
      hs_drive <= hs_nxt;
      hs_zero <= zero_nxt;
      payload_ok <= pay_nxt;
      lane_ready <= rdy_nxt;
      ulps_active <= ulps_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- verif/dts_lane_seq_asserts.sv ----
// port checks for the lane sequencer
`timescale 1ns/100ps
`default_nettype none
module dts_lane_seq_asserts #(
  parameter int WAKE_CYC = 40,
  parameter int INIT_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_lane_run,
  input wire logic lp_p,
  input wire logic lp_n,
  input wire logic hs_drive,
  input wire logic hs_zero,
  input wire logic payload_ok,
  input wire logic lane_ready,
  input wire logic ulps_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // figures below hold for a 1000 ps unit interval
  a_prep_len: assert property ($fell(lp_n) && !lp_p |-> !hs_drive[*2] ##[0:1] hs_drive)
    else $error("prepare length");
  a_zero_len: assert property ($rose(hs_drive) |-> hs_zero[*5] ##1 !hs_zero)
    else $error("zero length");
  a_trail_min: assert property ($fell(payload_ok) |-> (hs_drive && !hs_zero)[*3])
    else $error("trail short");
  a_eot_max: assert property ($fell(payload_ok) |-> ##[3:4] (lp_p && lp_n))
    else $error("end of burst late");
  a_exit_hold: assert property ($fell(hs_drive) |-> (lp_p && lp_n && !lane_ready)[*4])
    else $error("stop state short");
  a_lp_len: assert property ($changed({lp_p, lp_n}) |=> $stable({lp_p, lp_n}))
    else $error("line state short");
  a_wake_len: assert property ($rose(lp_p) && ulps_active |-> ##39 (lp_p && !lp_n))
    else $error("wake mark short");
  a_clk_lead: assert property ($fell(lp_p) && lp_n |-> clk_lane_run)
    else $error("entry without clock lane");
  a_init_hold: assert property ($rose(rst_n) |-> !lane_ready[*8] ##10 !lane_ready)
    else $error("ready too early");
  c_burst: cover property ($fell(payload_ok));
  c_ulps: cover property ($rose(ulps_active));
  c_wait: cover property (!lane_ready && !clk_lane_run);
endmodule
bind dts_lane_seq dts_lane_seq_asserts #(.WAKE_CYC(WAKE_CYC), .INIT_CYC(INIT_CYC)) chk (.*);
`default_nettype wire

// ---- verif/dts_rx_model.sv ----
// receiver model watching one data lane
`timescale 1ns/100ps
`default_nettype none
module dts_rx_model (
  input wire logic clk,
  input wire logic lp_p,
  input wire logic lp_n,
  input wire logic payload_ok,
  output logic [7:0] bursts = 8'h00
);
  logic [7:0] t_r;
  logic pay_r;
  // termination taken as on at once, inside its bound
  always @(posedge clk) begin
    t_r <= (lp_p || lp_n) ? 8'h00 : t_r + 8'h01;
    pay_r <= payload_ok;
    // data before settle ends is not counted
    if (payload_ok && !pay_r && t_r > 8'h03) bursts <= bursts + 8'h01;
  end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the lane sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, tx_req = 0, tx_last = 0, ulps_req = 0, ulps_exit = 0;
  logic run = 1, bclk = 0;
  logic [15:0] ui_ps = 16'h03E8;
  logic lp_p, lp_n, hs_drive, hs_zero, payload_ok, lane_ready, ulps_active;
  logic [7:0] bursts;
  int mismatches = 0, total_checks = 0, cyc = 0;
  wire [6:0] o = {lp_p, lp_n, hs_drive, hs_zero, payload_ok, lane_ready, ulps_active};
  always #12.5 clk = ~clk;
  initial #7 forever #100 bclk = ~bclk;
  dts_lane_seq #(.WAKE_CYC(40), .INIT_CYC(20)) dut (.clk(clk), .rst_n(rst_n), .ui_ps(ui_ps),
    .tx_req(tx_req), .tx_last(tx_last), .ulps_req(ulps_req), .ulps_exit(ulps_exit),
    .clk_lane_run(run), .byte_clk(bclk), .lp_p(lp_p), .lp_n(lp_n), .hs_drive(hs_drive),
    .hs_zero(hs_zero), .payload_ok(payload_ok), .lane_ready(lane_ready),
    .ulps_active(ulps_active));
  dts_rx_model rx (.clk(clk), .lp_p(lp_p), .lp_n(lp_n), .payload_ok(payload_ok), .bursts(bursts));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // wait for an output pattern, then count how long it stands
  task automatic seg(input logic [6:0] v, input int n);
    int k;
    for (k = 0; o !== v && k < 99; k++) @(negedge clk);
    for (k = 0; o === v && k < 99; k++) @(negedge clk);
    chk(k, n);
  endtask
  task automatic burst(input int hold);
    @(posedge clk) #2 tx_req = 1;
    @(posedge clk) #2 tx_req = 0;
    seg(7'h20, 2);
    seg(7'h00, 2);
    seg(7'h18, 5);
    chk(o, 7'h14);
    repeat (hold) @(posedge clk);
    @(posedge clk) #2 tx_last = 1;
    @(posedge clk) #2 tx_last = 0;
    @(negedge clk);
    seg(7'h10, 3);
    seg(7'h60, 4);
    chk(o, 7'h62);
  endtask
  task automatic ulps();
    @(posedge clk) #2 ulps_req = 1;
    @(posedge clk) #2 ulps_req = 0;
    @(negedge clk);
    seg(7'h40, 2);
    seg(7'h00, 2);
    repeat (8) @(negedge clk);
    chk(o, 7'h01);
    @(posedge clk) #2 ulps_exit = 1;
    @(posedge clk) #2 ulps_exit = 0;
    @(negedge clk);
    seg(7'h41, 40);
    seg(7'h60, 4);
    chk(o, 7'h62);
  endtask
  task automatic init_hold();
    repeat (8) @(posedge clk);
    #2 rst_n = 1;
    // LP-11 for INIT_CYC cycles after release, ready shows one edge later
    repeat (21) @(negedge clk);
    chk(o, 7'h60);
    @(negedge clk);
    chk(o, 7'h62);
  endtask
  // request parked until the clock lane runs
  task automatic parked();
    @(posedge clk) #2 run = 0;
    @(posedge clk) #2 tx_req = 1;
    repeat (12) @(negedge clk);
    chk(o, 7'h60);
    @(posedge clk) #2 run = 1;
  endtask
  initial begin
    init_hold();
    burst(0);
    burst(3);
    parked();
    burst(1);
    ulps();
    chk(bursts, 8'h03);
    tally_and_finish();
  end
endmodule
`default_nettype wire
